// file: verilog/bpoc_pkg.sv
// Constants and types for the bridge PWM output control block.
// Assumes one 20 MHz instruction clock; timer and duty compare on that clock.
// Operation
// RL1: A new full-bridge direction takes effect from the next PWM cycle.
// RL2: Four timer counts before period end, B and D go inactive, A/C swap.
// RL3: Modulation in the new direction resumes at the following period start.
// RL4: The direction bit may be written anywhere in the PWM cycle.
// RL5: Full-bridge directions use no dead-band delay.
// RL6: Shutdown sources are fault pin low or comparator high, chosen by select.
// RL7: A shutdown event sets the flag; flag zero means normal running. Here the outputs stay shut after the flag clears until the next period start.
// RL8: The flag stays set until software or auto-restart clears it.
// RL9: Shutdown forces enabled pins to per-pair safe states: one, zero or float.
// RL10: Shutdown is level based and persists while the source level stays.
// RL11: Software writes to the flag are ignored while the condition persists.
// RL12: After restart, PWM output resumes only at the next period start.
// RL13: Software setting the flag enters shutdown without a hardware source.
// RL14: With auto-restart, a software shutdown is cleared at once, restart next period.
// RL15: With auto-restart, hardware clears the flag when the condition goes away.
// RL16: Half-bridge dead-band applies only on inactive-to-active transitions.
// RL17: Dead-band length is a seven-bit count of instruction cycles.
// RL18: Single mode routes the same PWM to every steering-enabled pin.
// RL19: While steering, the two-bit polarity select sets steered pin polarity.
// RL20: In steering, safe states touch only enabled pins.
// RL21: Sync bit zero applies new steering enables right after the write.
// RL22: Sync bit one defers new steering enables to the next period start.
// RL23: Forward: A active, D modulated; reverse: C active, B modulated.
// RL24: Half-bridge drives PWM on A and its complement on B.
// RL25: A direction write in the last four counts applies in the next period.
`default_nettype none

package bpoc_pkg;

  // ------------------------------------------------------------
  // Modes, pins and encodings
  // ------------------------------------------------------------
  localparam logic [1:0] MODE_UPPER_PWM = 2'h3;
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_HALF = 2'h2;
  localparam int CFG_FULL_BIT = 0;
  localparam int CFG_DIR_BIT = 1;
  localparam int POL_AC_LOW_BIT = 1;
  localparam int POL_BD_LOW_BIT = 0;
  localparam int SRC_CMP1_BIT = 0;
  localparam int SRC_CMP2_BIT = 1;
  localparam int SRC_FAULT_BIT = 2;
  localparam int SAFE_TRI_BIT = 1;
  localparam int SAFE_LEVEL_BIT = 0;
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_C = 2;
  localparam int PIN_D = 3;
  localparam logic [3:0] HALF_PINS = 4'h3;
  localparam logic [3:0] FULL_PINS = 4'hf;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam logic [7:0] DIR_LEAD_COUNTS = 8'h04;
  localparam int CLK_PERIOD_NS = 50;
  localparam int INSTR_CYCLE_NS = 50;
  localparam int DB_CYCLES_PER_UNIT = INSTR_CYCLE_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {BPOC_OFF, BPOC_SINGLE, BPOC_HALF, BPOC_FULL} bpoc_mode_t;

  typedef struct packed {
    logic [3:0] drive;
    logic [3:0] oe;
  } bpoc_pins_t;

  localparam bpoc_pins_t PINS_RESET = '{drive: 4'h0, oe: 4'h0};

  typedef struct packed {
    logic fault_s1;
    logic fault_s2;
    logic [1:0] cmp_s1;
    logic [1:0] cmp_s2;
    logic flag;
    logic shut;
    logic dir_unmod;
    logic dir_mod;
    logic blank;
    logic [3:0] steer_eff;
    logic [6:0] db_a;
    logic [6:0] db_b;
    bpoc_pins_t pins;
  } bpoc_state_t;

endpackage : bpoc_pkg

`default_nettype wire

// file: verilog/bpoc_output_control.sv
// Output control of an enhanced PWM channel: direction change, shutdown,
// restart, half-bridge dead-band and single-output steering.
// Assumes timer, duty compare and control bits come from the same clock.
`default_nettype none

module bpoc_output_control
  import bpoc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic timer_tick_in,
  input wire logic [7:0] timer_count_in,
  input wire logic [7:0] period_value_in,
  input wire logic pwm_duty_in,
  input wire logic [1:0] channel_mode_upper_in,
  input wire logic [1:0] output_config_select_in,
  input wire logic [1:0] output_polarity_select_in,
  input wire logic [6:0] deadband_delay_in,
  input wire logic auto_restart_enable_in,
  input wire logic [2:0] shutdown_source_select_in,
  input wire logic [1:0] pair_ac_safe_state_in,
  input wire logic [1:0] pair_bd_safe_state_in,
  input wire logic flag_set_in,
  input wire logic flag_clear_in,
  input wire logic fault_input_pin_n_in,
  input wire logic [1:0] comparator_out_in,
  input wire logic [3:0] steer_pin_enables_in,
  input wire logic steer_sync_select_in,
  output var bpoc_pins_t pins_out,
  output logic shutdown_event_flag_out,
  output logic shutdown_active_out
);

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  bpoc_state_t st_reg;
  bpoc_state_t st_next;
  bpoc_mode_t mode;
  logic direction_select_bit;
  logic period_start;
  logic lead_point;
  logic hw_cond;
  logic [3:0] pins_enabled;
  logic [3:0] act;
  logic [3:0] pol_low;
  logic [3:0] safe_drive;
  logic [3:0] safe_tri;

  assign direction_select_bit = output_config_select_in[CFG_DIR_BIT];

  always_comb begin
    if (channel_mode_upper_in != MODE_UPPER_PWM) begin
      mode = BPOC_OFF;
    end else if (output_config_select_in[CFG_FULL_BIT]) begin
      mode = BPOC_FULL;
    end else if (output_config_select_in == CFG_HALF) begin
      mode = BPOC_HALF;
    end else begin
      mode = BPOC_SINGLE; // [RL18]
    end
  end

  assign period_start = timer_tick_in && (timer_count_in == period_value_in);
  // Leaves four counts before the wrap; later writes wait for the next one
  assign lead_point = timer_tick_in &&
    (timer_count_in == 8'(period_value_in - DIR_LEAD_COUNTS)); // [RL2] [RL25]

  // Reads only the second synchroniser stage
  assign hw_cond = (shutdown_source_select_in[SRC_FAULT_BIT] && !st_reg.fault_s2) ||
    (shutdown_source_select_in[SRC_CMP1_BIT] && st_reg.cmp_s2[0]) ||
    (shutdown_source_select_in[SRC_CMP2_BIT] && st_reg.cmp_s2[1]); // [RL6] [RL10]

  assign pol_low = {output_polarity_select_in[POL_BD_LOW_BIT],
    output_polarity_select_in[POL_AC_LOW_BIT],
    output_polarity_select_in[POL_BD_LOW_BIT],
    output_polarity_select_in[POL_AC_LOW_BIT]}; // [RL19]

  assign safe_drive = {pair_bd_safe_state_in[SAFE_LEVEL_BIT],
    pair_ac_safe_state_in[SAFE_LEVEL_BIT],
    pair_bd_safe_state_in[SAFE_LEVEL_BIT],
    pair_ac_safe_state_in[SAFE_LEVEL_BIT]};
  assign safe_tri = {pair_bd_safe_state_in[SAFE_TRI_BIT],
    pair_ac_safe_state_in[SAFE_TRI_BIT],
    pair_bd_safe_state_in[SAFE_TRI_BIT],
    pair_ac_safe_state_in[SAFE_TRI_BIT]};

  // ------------------------------------------------------------
  // Pin activity per mode
  // ------------------------------------------------------------
  always_comb begin
    act = 4'h0;
    pins_enabled = 4'h0;
    unique case (mode)
      BPOC_OFF: begin
        pins_enabled = 4'h0;
      end
      BPOC_SINGLE: begin
        pins_enabled = st_reg.steer_eff; // [RL18] [RL21] [RL22]
        act = {4{pwm_duty_in}};
      end
      BPOC_HALF: begin
        pins_enabled = HALF_PINS;
        act[PIN_A] = pwm_duty_in && (st_reg.db_a >= deadband_delay_in); // [RL16] [RL24]
        act[PIN_B] = !pwm_duty_in && (st_reg.db_b >= deadband_delay_in); // [RL16] [RL24]
      end
      BPOC_FULL: begin
        // No dead-band here; at a direction change A, C and the blanked B or D switch in the same cycle
        pins_enabled = FULL_PINS; // [RL5]
        act[PIN_A] = !st_reg.dir_unmod; // [RL23]
        act[PIN_C] = st_reg.dir_unmod; // [RL23]
        act[PIN_D] = pwm_duty_in && !st_reg.dir_mod && !st_reg.blank; // [RL2] [RL23]
        act[PIN_B] = pwm_duty_in && st_reg.dir_mod && !st_reg.blank; // [RL2] [RL23]
      end
    endcase
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.fault_s1 = fault_input_pin_n_in;
    st_next.fault_s2 = st_reg.fault_s1;
    st_next.cmp_s1 = comparator_out_in;
    st_next.cmp_s2 = st_reg.cmp_s1;

    // Set beats clear; a software set with auto-restart lives one cycle
    if (hw_cond) begin
      st_next.flag = 1'b1; // [RL7] [RL10] [RL11]
    end else if (flag_set_in) begin
      st_next.flag = 1'b1; // [RL13]
    end else if (auto_restart_enable_in || flag_clear_in) begin
      st_next.flag = 1'b0; // [RL8] [RL14] [RL15]
    end

    if (hw_cond || st_reg.flag) begin
      st_next.shut = 1'b1; // [RL9]
    end else if (period_start) begin
      st_next.shut = 1'b0; // [RL12] [RL14]
    end

    if (!steer_sync_select_in || period_start) begin
      st_next.steer_eff = steer_pin_enables_in; // [RL21] [RL22]
    end

    if (mode != BPOC_FULL) begin
      st_next.dir_unmod = direction_select_bit;
      st_next.dir_mod = direction_select_bit;
      st_next.blank = 1'b0;
    end else begin
      // Bit is sampled any time; only the lead point commits it
      if (lead_point && !st_reg.blank && direction_select_bit != st_reg.dir_unmod) begin
        st_next.dir_unmod = direction_select_bit; // [RL1] [RL2] [RL4] [RL25]
        st_next.blank = 1'b1; // [RL2]
      end
      if (period_start) begin
        st_next.dir_mod = st_reg.dir_unmod; // [RL3]
        st_next.blank = 1'b0; // [RL3]
      end
    end

    // Counters saturate at 127; delay is in instruction cycles
    if (!pwm_duty_in || mode != BPOC_HALF) begin
      st_next.db_a = 7'h00;
    end else if (st_reg.db_a != 7'h7f) begin
      st_next.db_a = 7'(st_reg.db_a + 7'(DB_CYCLES_PER_UNIT)); // [RL17]
    end
    if (pwm_duty_in || mode != BPOC_HALF) begin
      st_next.db_b = 7'h00;
    end else if (st_reg.db_b != 7'h7f) begin
      st_next.db_b = 7'(st_reg.db_b + 7'(DB_CYCLES_PER_UNIT)); // [RL17]
    end

    // Safe levels are absolute; polarity does not apply to them
    if (st_reg.shut) begin
      st_next.pins.drive = safe_drive & pins_enabled; // [RL9] [RL20]
      st_next.pins.oe = pins_enabled & ~safe_tri; // [RL9] [RL20]
    end else begin
      st_next.pins.drive = (act ^ pol_low) & pins_enabled;
      st_next.pins.oe = pins_enabled;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      st_reg <= '{fault_s1: 1'b1, fault_s2: 1'b1, cmp_s1: 2'h0, cmp_s2: 2'h0,
        flag: 1'b0, shut: 1'b0, dir_unmod: 1'b0, dir_mod: 1'b0, blank: 1'b0,
        steer_eff: 4'h0, db_a: 7'h00, db_b: 7'h00, pins: PINS_RESET};
    end else if (clk_en_in) begin
      st_reg <= st_next;
    end
  end

  assign pins_out = st_reg.pins;
  assign shutdown_event_flag_out = st_reg.flag;
  assign shutdown_active_out = st_reg.shut;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  AST_FLAG_ON_COND: assert property ( // [RL7]
    clk_en_in && hw_cond |=> shutdown_event_flag_out && shutdown_active_out)
    else $error("flag not set by shutdown source");

  AST_FLAG_HOLDS: assert property ( // [RL8]
    clk_en_in && shutdown_event_flag_out && !auto_restart_enable_in && !flag_clear_in
    |=> shutdown_event_flag_out)
    else $error("flag dropped without a clear");

  AST_CLEAR_IGNORED: assert property ( // [RL11]
    clk_en_in && hw_cond && flag_clear_in |=> shutdown_event_flag_out)
    else $error("clear accepted during shutdown condition");

  AST_SW_SHUTDOWN: assert property ( // [RL13]
    clk_en_in && flag_set_in && !hw_cond |=> shutdown_event_flag_out ##1
    (!clk_en_in || shutdown_active_out))
    else $error("software set did not enter shutdown");

  AST_AUTO_CLEAR: assert property ( // [RL15]
    clk_en_in && auto_restart_enable_in && !hw_cond && !flag_set_in
    |=> !shutdown_event_flag_out)
    else $error("auto-restart did not clear flag");

  AST_RESTART_AT_PERIOD: assert property ( // [RL12]
    $fell(shutdown_active_out) |-> $past(period_start) && $past(clk_en_in))
    else $error("restart outside period start");

  AST_SAFE_DRIVE: assert property ( // [RL9]
    clk_en_in && shutdown_active_out && pins_enabled[PIN_A] &&
    pair_ac_safe_state_in == 2'h1 |=> pins_out.oe[PIN_A] && pins_out.drive[PIN_A])
    else $error("pin A not at safe level");

  AST_SAFE_UNTOUCHED: assert property ( // [RL20]
    clk_en_in && shutdown_active_out && !pins_enabled[PIN_C] |=> !pins_out.oe[PIN_C])
    else $error("disabled pin driven in shutdown");

  AST_DIR_AT_LEAD: assert property ( // [RL1]
    mode == BPOC_FULL && $changed(st_reg.dir_unmod) && $past(mode) == BPOC_FULL
    |-> $past(lead_point) && $past(clk_en_in))
    else $error("direction changed off the lead point");

  AST_BLANK_BD: assert property ( // [RL2]
    clk_en_in && !st_reg.shut && mode == BPOC_FULL && st_reg.blank
    |=> pins_out.drive[PIN_B] == $past(pol_low[PIN_B]) &&
    pins_out.drive[PIN_D] == $past(pol_low[PIN_D]))
    else $error("modulated outputs active while blanked");

  AST_RESUME_AT_PERIOD: assert property ( // [RL3]
    $fell(st_reg.blank) && $past(mode) == BPOC_FULL && mode == BPOC_FULL
    |-> $past(period_start))
    else $error("modulation resumed off period start");

  AST_DEADBAND: assert property ( // [RL16]
    clk_en_in && mode == BPOC_HALF && !st_reg.shut && deadband_delay_in != 7'h00 &&
    st_reg.db_a == 7'h00 |=> pins_out.drive[PIN_A] == $past(pol_low[PIN_A]))
    else $error("half-bridge A active before dead-band");

  AST_STEER_DEFER: assert property ( // [RL22]
    clk_en_in && steer_sync_select_in && !period_start |=> $stable(st_reg.steer_eff))
    else $error("steering changed mid-period");

  // ------------------------------------------------------------
  // Assertions on causes and per-mode pin levels
  // ------------------------------------------------------------
  AST_SHUT_WHILE_FLAG: assert property ( // [RL12]
    clk_en_in && shutdown_event_flag_out
    |=> shutdown_active_out)
    else $error("outputs restarted while flag set");

  AST_SHUT_CAUSE: assert property ( // [RL7]
    $rose(shutdown_active_out)
    |-> $past(hw_cond) || $past(shutdown_event_flag_out))
    else $error("shutdown entered without a cause");

  AST_FLAG_RISE_CAUSE: assert property ( // [RL13]
    $rose(shutdown_event_flag_out)
    |-> $past(hw_cond) || $past(flag_set_in))
    else $error("flag set without source or software set");

  AST_FLAG_FALL_CAUSE: assert property ( // [RL8]
    $fell(shutdown_event_flag_out)
    |-> $past(auto_restart_enable_in) || $past(flag_clear_in))
    else $error("flag cleared without restart or clear");

  AST_SAFE_FLOAT: assert property ( // [RL9]
    clk_en_in && shutdown_active_out && pair_bd_safe_state_in[SAFE_TRI_BIT]
    |=> !pins_out.oe[PIN_B] && !pins_out.oe[PIN_D])
    else $error("pair B/D driven while set to float");

  AST_SAFE_ZERO: assert property ( // [RL9]
    clk_en_in && shutdown_active_out && pins_enabled[PIN_C] &&
    pair_ac_safe_state_in == 2'h0 |=> pins_out.oe[PIN_C] && !pins_out.drive[PIN_C])
    else $error("pin C not driven low in shutdown");

  AST_FULL_FWD: assert property ( // [RL23]
    clk_en_in && !shutdown_active_out && mode == BPOC_FULL && !st_reg.dir_unmod
    |=> pins_out.drive[PIN_A] != $past(output_polarity_select_in[POL_AC_LOW_BIT]) &&
    pins_out.drive[PIN_C] == $past(output_polarity_select_in[POL_AC_LOW_BIT]) &&
    pins_out.drive[PIN_B] == $past(output_polarity_select_in[POL_BD_LOW_BIT]))
    else $error("forward levels wrong on A, B or C");

  AST_FULL_REV: assert property ( // [RL23]
    clk_en_in && !shutdown_active_out && mode == BPOC_FULL && st_reg.dir_unmod
    |=> pins_out.drive[PIN_C] != $past(output_polarity_select_in[POL_AC_LOW_BIT]) &&
    pins_out.drive[PIN_A] == $past(output_polarity_select_in[POL_AC_LOW_BIT]) &&
    pins_out.drive[PIN_D] == $past(output_polarity_select_in[POL_BD_LOW_BIT]))
    else $error("reverse levels wrong on A, C or D");

  AST_HALF_NO_OVERLAP: assert property ( // [RL24]
    clk_en_in && mode == BPOC_HALF && !shutdown_active_out &&
    output_polarity_select_in == 2'h0 |=> !(pins_out.drive[PIN_A] && pins_out.drive[PIN_B]))
    else $error("half-bridge A and B active together");

  AST_HALF_CD_OFF: assert property ( // [RL24]
    clk_en_in && mode == BPOC_HALF
    |=> !pins_out.oe[PIN_C] && !pins_out.oe[PIN_D])
    else $error("half-bridge drives C or D");

  AST_OFF_RELEASED: assert property ( // [RL18]
    clk_en_in && mode == BPOC_OFF
    |=> pins_out.oe == 4'h0)
    else $error("pins driven outside PWM mode");

  AST_STEER_NOW: assert property ( // [RL21]
    clk_en_in && !steer_sync_select_in
    |=> st_reg.steer_eff == $past(steer_pin_enables_in))
    else $error("steering update not applied at once");

  AST_STEER_MASK: assert property ( // [RL18]
    clk_en_in && mode == BPOC_SINGLE
    |=> (pins_out.oe & ~$past(st_reg.steer_eff)) == 4'h0)
    else $error("unsteered pin driven in single mode");

  AST_DEADBAND_B: assert property ( // [RL16]
    clk_en_in && mode == BPOC_HALF && !st_reg.shut && deadband_delay_in != 7'h00 &&
    st_reg.db_b == 7'h00 |=> pins_out.drive[PIN_B] == $past(pol_low[PIN_B]))
    else $error("half-bridge B active before dead-band");

  COV_DIR_CHANGE: cover property ($rose(st_reg.blank));
  COV_HW_SHUTDOWN: cover property (hw_cond ##1 shutdown_active_out ##[1:200] !shutdown_active_out);
  COV_SW_SHUTDOWN: cover property (flag_set_in && !hw_cond ##1 shutdown_event_flag_out);
  COV_STEER: cover property (mode == BPOC_SINGLE && st_reg.steer_eff == 4'hf);
  COV_AUTO_RESTART: cover property (shutdown_event_flag_out && auto_restart_enable_in ##1
    !shutdown_event_flag_out);

endmodule : bpoc_output_control

`default_nettype wire

// file: sim/bpoc_switch_model.sv
// Far-side model: gate drivers with pull-downs, fault pin and comparators.
// Assumes the bench changes its requests on the falling clock edge.
`default_nettype none

module bpoc_switch_model
  import bpoc_pkg::*;
(
  input wire logic clk_in,
  input wire bpoc_pins_t pins_in,
  input wire logic slow_in,
  input wire logic fault_req_in,
  input wire logic [1:0] cmp_req_in,
  output logic fault_pin_n_out,
  output logic [1:0] cmp_out,
  output logic [3:0] level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic fault_reg = 1'b0;
  logic [1:0] cmp_reg = 2'h0;

  // ------------------------------------------------------------
  // Sources and pin levels
  // ------------------------------------------------------------
  // Slow source reaches its pin one cycle late
  always @(posedge clk_in) begin
    fault_reg <= fault_req_in;
    cmp_reg <= cmp_req_in;
  end
  assign fault_pin_n_out = !(slow_in ? fault_reg : fault_req_in);
  assign cmp_out = slow_in ? cmp_reg : cmp_req_in;
  // Released gate lines fall to the external pull-downs
  assign level_out = pins_in.drive & pins_in.oe;
endmodule : bpoc_switch_model

`default_nettype wire

// file: sim/tb.sv
// Bench for the bridge PWM output control block, one task per scenario.
// Assumes the counter below stands in for the period timer and duty compare.
`default_nettype none

module tb
  import bpoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] PER = 8'h13;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] cnt = 8'h00;
  logic [7:0] dty = 8'h0a;
  logic [1:0] cfg = 2'h1, pol = 2'h0, sac = 2'h0, sbd = 2'h0, creq = 2'h0, cmp;
  logic [1:0] mode_up = MODE_UPPER_PWM;
  logic en = 1'b1;
  logic [6:0] db = 7'h00;
  logic [2:0] src = 3'h0;
  logic [3:0] steer = 4'h0, lvl;
  logic arst = 1'b0, fset = 1'b0, fclr = 1'b0, sync = 1'b0, freq = 1'b0, slow = 1'b0;
  logic fault_n, flag, act;
  bpoc_pins_t pins;
  int failures = 0, n_tests = 0, cyc = 0;

  bpoc_output_control dut (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(en),
    .timer_tick_in(1'b1),
    .timer_count_in(cnt),
    .period_value_in(PER),
    .pwm_duty_in(cnt < dty),
    .channel_mode_upper_in(mode_up),
    .output_config_select_in(cfg),
    .output_polarity_select_in(pol),
    .deadband_delay_in(db),
    .auto_restart_enable_in(arst),
    .shutdown_source_select_in(src),
    .pair_ac_safe_state_in(sac),
    .pair_bd_safe_state_in(sbd),
    .flag_set_in(fset),
    .flag_clear_in(fclr),
    .fault_input_pin_n_in(fault_n),
    .comparator_out_in(cmp),
    .steer_pin_enables_in(steer),
    .steer_sync_select_in(sync),
    .pins_out(pins),
    .shutdown_event_flag_out(flag),
    .shutdown_active_out(act)
  );

  bpoc_switch_model bridge (
    .clk_in(clk_sys_in),
    .pins_in(pins),
    .slow_in(slow),
    .fault_req_in(freq),
    .cmp_req_in(creq),
    .fault_pin_n_out(fault_n),
    .cmp_out(cmp),
    .level_out(lvl)
  );

  // ------------------------------------------------------------
  // Clock, period counter, hang guard
  // ------------------------------------------------------------
  initial begin
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  always @(negedge clk_sys_in) begin
    cnt <= (!reset_n_in || cnt == PER) ? 8'h00 : cnt + 8'h01;
  end
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp_pins(input string nm, input logic [3:0] ev, input logic [3:0] eo);
    n_tests++;
    if ({lvl, pins.oe} !== {ev, eo}) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, {ev, eo}, {lvl, pins.oe});
    end
  endtask : cmp_pins

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %b got %b", nm, e, g);
    end
  endtask : cmp_bit

  task automatic at(input int c);
    do begin
      @(negedge clk_sys_in);
      #1;
    end while (cnt !== 8'(c));
  endtask : at

  task automatic pulse(input logic set);
    fset = set;
    fclr = !set;
    @(negedge clk_sys_in);
    #1;
    fset = 1'b0;
    fclr = 1'b0;
  endtask : pulse

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_dir;
    at(6);
    cmp_pins("fwd_hi", 4'h9, 4'hf);
    at(13);
    cmp_pins("fwd_lo", 4'h1, 4'hf);
    // Long duty so blanking of B and D is visible
    dty = 8'h12;
    at(3);
    cfg = 2'h3;
    at(14);
    cmp_pins("dir_wait", 4'h9, 4'hf);
    at(18);
    cmp_pins("dir_lead", 4'h4, 4'hf);
    at(6);
    cmp_pins("rev_hi", 4'h6, 4'hf);
    at(17);
    cfg = 2'h1;
    at(6);
    cmp_pins("late_wr", 4'h6, 4'hf);
    at(18);
    cmp_pins("late_lead", 4'h1, 4'hf);
    dty = 8'h0a;
  endtask : t_dir

  task automatic t_shut;
    src = 3'h4;
    sac = 2'h1;
    sbd = 2'h2;
    at(2);
    freq = 1'b1;
    at(8);
    cmp_bit("flag_hw", 1'b1, flag);
    cmp_pins("safe_float", 4'h5, 4'h5);
    pulse(1'b0);
    at(8);
    cmp_bit("flag_held", 1'b1, flag);
    freq = 1'b0;
    at(14);
    pulse(1'b0);
    at(17);
    cmp_bit("flag_sw_clr", 1'b0, flag);
    cmp_bit("act_wait", 1'b1, act);
    at(4);
    cmp_pins("restart", 4'h9, 4'hf);
  endtask : t_shut

  task automatic t_auto;
    arst = 1'b1;
    slow = 1'b1;
    src = 3'h1;
    sac = 2'h0;
    sbd = 2'h1;
    at(2);
    creq = 2'h1;
    at(9);
    cmp_bit("flag_cmp", 1'b1, flag);
    cmp_pins("safe_drive", 4'ha, 4'hf);
    creq = 2'h0;
    at(16);
    cmp_bit("flag_auto", 1'b0, flag);
    cmp_bit("act_auto", 1'b1, act);
    at(5);
    cmp_bit("act_off", 1'b0, act);
    slow = 1'b0;
  endtask : t_auto

  task automatic t_sw;
    src = 3'h0;
    at(3);
    pulse(1'b1);
    at(6);
    cmp_bit("sw_auto_flag", 1'b0, flag);
    cmp_bit("sw_auto_act", 1'b1, act);
    at(4);
    cmp_bit("sw_auto_end", 1'b0, act);
    arst = 1'b0;
    pulse(1'b1);
    at(10);
    cmp_bit("sw_flag", 1'b1, flag);
    cmp_bit("sw_act", 1'b1, act);
    pulse(1'b0);
  endtask : t_sw

  task automatic t_db;
    cfg = 2'h2;
    db = 7'h05;
    at(19);
    at(5);
    cmp_pins("db_a_wait", 4'h0, 4'h3);
    at(6);
    cmp_pins("db_a_on", 4'h1, 4'h3);
    at(15);
    cmp_pins("db_b_wait", 4'h0, 4'h3);
    at(16);
    cmp_pins("db_b_on", 4'h2, 4'h3);
  endtask : t_db

  task automatic t_steer;
    cfg = 2'h0;
    pol = 2'h2;
    steer = 4'h5;
    at(19);
    at(6);
    cmp_pins("st_hi", 4'h0, 4'h5);
    at(14);
    cmp_pins("st_lo", 4'h5, 4'h5);
    sync = 1'b1;
    steer = 4'ha;
    at(18);
    cmp_pins("st_defer", 4'h5, 4'h5);
    at(6);
    cmp_pins("st_new", 4'ha, 4'ha);
    sync = 1'b0;
    steer = 4'h3;
    at(9);
    cmp_pins("st_now", 4'h2, 4'h3);
    src = 3'h4;
    sac = 2'h1;
    sbd = 2'h0;
    freq = 1'b1;
    at(15);
    cmp_pins("st_safe", 4'h1, 4'h3);
    freq = 1'b0;
  endtask : t_steer

  // Frozen by the enable, then released by leaving PWM mode
  task automatic t_off;
    en = 1'b0;
    mode_up = 2'h0;
    at(18);
    cmp_pins("frozen", 4'h1, 4'h3);
    cmp_bit("frozen_flag", 1'b1, flag);
    en = 1'b1;
    at(1);
    cmp_pins("mode_off", 4'h0, 4'h0);
  endtask : t_off

  initial begin
    repeat (10) @(negedge clk_sys_in);
    cmp_pins("reset_pins", 4'h0, 4'h0);
    cmp_bit("reset_flag", 1'b0, flag);
    reset_n_in = 1'b1;
    at(19);
    t_dir();
    t_shut();
    t_auto();
    t_sw();
    t_db();
    t_steer();
    t_off();
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
